/* File: rtl/adc_trim_regs.sv */
// converter core trim register bank with ahb-lite slave and fuse defaults
//
// Functional notes
// [RULE1] Core A keeps an 8-bit timing trim for single mode, second input, fg cal on.
// [RULE2] Core B keeps an 8-bit timing trim for single mode, second input, fg cal on.
// [RULE3] Core A gets a 12-bit offset trim in dual mode on the first input with fg cal.
// [RULE4] Core A gets a separate 12-bit offset trim in dual mode on the second input with fg cal.
// [RULE5] Core A gets a further offset trim whenever single mode samples the first input.
// [RULE6] Trim defaults come from fuse storage, stay readable and can be overwritten.
// [RULE7] Offset words hold the value in bits 11:0 and reserved bits 15:12 read zero after reset.
// [RULE8] Each timing trim shifts its core's sampling instant and software reads and adjusts it.
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module adc_trim_regs (
   // clock and reset
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   // ahb-lite slave
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic [31:0]                      hrdata,
   output logic                             hresp,
   // operating mode from the converter control, same clock
   input  wire trim_pkg::op_mode_t          op_mode,
   // fuse storage read port
   output logic                             fuse_req,
   output logic [trim_pkg::ENT_W-1:0]       fuse_addr,
   input  wire logic                        fuse_ack,
   input  wire logic [trim_pkg::TRIM_W-1:0] fuse_data,
   // selected trims towards the converter cores
   output trim_pkg::trim_out_t              trim_out
);

   // ==========================================================================
   // declarations
   logic [trim_pkg::TRIM_W-1:0]  trim_q [trim_pkg::NUM_TRIMS];
   logic [trim_pkg::TRIM_W-1:0]  trim_d [trim_pkg::NUM_TRIMS];
   logic                         dp_wr_q, dp_wr_d;
   logic                         dp_hit_q, dp_hit_d;
   logic [trim_pkg::IDX_W-1:0]   dp_idx_q, dp_idx_d;
   logic                         rd_wait_q, rd_wait_d;
   logic [31:0]                  hrdata_q, hrdata_d;
   logic                         reload_q, reload_d;
   trim_pkg::trim_out_t          out_q, out_d;
   logic                         addr_ok;
   logic                         sw_we;
   logic                         ld_we;
   logic [trim_pkg::ENT_W-1:0]   ld_ent;
   logic [trim_pkg::TRIM_W-1:0]  ld_data;
   logic                         ld_busy;
   logic                         ld_done;

   // ==========================================================================
   // fuse sequencer
   trim_fuse_loader u_loader (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .reload    (reload_q),
      .fuse_req  (fuse_req),
      .fuse_addr (fuse_addr),
      .fuse_ack  (fuse_ack),
      .fuse_data (fuse_data),
      .ld_we     (ld_we),
      .ld_ent    (ld_ent),
      .ld_data   (ld_data),
      .busy      (ld_busy),
      .done      (ld_done)
   );

   // ==========================================================================
   // ahb-lite address and data phase
   // only single word transfers are expected, so hsize is not decoded
   assign addr_ok = (haddr[31:trim_pkg::ADDR_LSB + trim_pkg::IDX_W] == '0);

   always_comb begin
      dp_wr_d   = 1'b0;
      dp_hit_d  = dp_hit_q;
      dp_idx_d  = dp_idx_q;
      rd_wait_d = 1'b0;
      if (hsel && hready && htrans[1]) begin
         dp_wr_d   = hwrite;
         rd_wait_d = !hwrite;                       // reads take one wait state
         dp_hit_d  = addr_ok;
         dp_idx_d  = haddr[trim_pkg::ADDR_LSB +: trim_pkg::IDX_W];
      end
   end

   // write commits at the end of the zero-wait data phase
   assign sw_we = dp_wr_q && dp_hit_q;

   // read mux sampled in the wait state, so a write just before is visible
   always_comb begin
      hrdata_d = hrdata_q;
      if (rd_wait_q) begin
         hrdata_d = 32'h0000_0000;                  // unmapped reads as zero
         if (dp_hit_q) begin
            for (int e = 0; e < trim_pkg::NUM_TRIMS; e++) begin
               if (dp_idx_q == trim_pkg::TRIM_IDX[e]) begin
                  hrdata_d[trim_pkg::TRIM_W-1:0] = trim_q[e];       // [RULE8]
               end
            end
            if (dp_idx_q == trim_pkg::IDX_STATUS) begin
               hrdata_d[trim_pkg::ST_LOAD_DONE]  = ld_done;
               hrdata_d[trim_pkg::ST_LOAD_BUSY]  = ld_busy;
               hrdata_d[trim_pkg::ST_A_TADJ_VLD] = out_q.a_tadj_vld;
               hrdata_d[trim_pkg::ST_B_TADJ_VLD] = out_q.b_tadj_vld;
               hrdata_d[trim_pkg::ST_A_OADJ_VLD] = out_q.a_oadj_vld;
            end
         end
      end
   end

   // reload request is a self-clearing pulse; the control word reads zero
   always_comb begin
      reload_d = 1'b0;
      if (sw_we && dp_idx_q == trim_pkg::IDX_CONTROL) begin
         reload_d = hwdata[trim_pkg::CTL_RELOAD] && !ld_busy;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_q   <= 1'b0;
         dp_hit_q  <= 1'b0;
         dp_idx_q  <= '0;
         rd_wait_q <= 1'b0;
         hrdata_q  <= 32'h0000_0000;
         reload_q  <= 1'b0;
      end else begin
         dp_wr_q   <= dp_wr_d;
         dp_hit_q  <= dp_hit_d;
         dp_idx_q  <= dp_idx_d;
         rd_wait_q <= rd_wait_d;
         hrdata_q  <= hrdata_d;
         reload_q  <= reload_d;
      end
   end

   assign hreadyout = !rd_wait_q;
   assign hrdata    = hrdata_q;
   assign hresp     = trim_pkg::HRESP_OKAY;

   // ==========================================================================
   // trim storage: fuse load wins over a software write in the same cycle,
   // software should poll the load-done status before adjusting trims
   for (genvar e = 0; e < trim_pkg::NUM_TRIMS; e++) begin : g_trim
      always_comb begin
         trim_d[e] = trim_q[e];
         if (sw_we && dp_idx_q == trim_pkg::TRIM_IDX[e]) begin
            trim_d[e] = hwdata[trim_pkg::TRIM_W-1:0]
                      & trim_pkg::TRIM_MASK[e];                     // [RULE8]
         end
         if (ld_we && ld_ent == trim_pkg::ENT_W'(e)) begin
            trim_d[e] = ld_data;                                    // [RULE6]
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trim_q <= '{default: trim_pkg::TRIM_RESET};                // [RULE7]
      end else begin
         trim_q <= trim_d;
      end
   end

   // ==========================================================================
   // trim selection by operating mode, registered towards the cores
   always_comb begin
      out_d = '0;
      if (!op_mode.dual && op_mode.inb && op_mode.fg_cal) begin
         out_d.a_tadj_vld = 1'b1;                                   // [RULE1]
         out_d.a_tadj     = trim_q[trim_pkg::ENT_A_SGL_INB_TADJ]
                            [trim_pkg::TADJ_W-1:0];
         out_d.b_tadj_vld = 1'b1;                                   // [RULE2]
         out_d.b_tadj     = trim_q[trim_pkg::ENT_B_SGL_INB_TADJ]
                            [trim_pkg::TADJ_W-1:0];
      end
      if (op_mode.dual && op_mode.fg_cal) begin
         out_d.a_oadj_vld = 1'b1;
         if (op_mode.inb) begin
            out_d.a_oadj = trim_q[trim_pkg::ENT_A_DUAL_INB_OADJ]
                           [trim_pkg::OADJ_W-1:0];                  // [RULE4]
         end else begin
            out_d.a_oadj = trim_q[trim_pkg::ENT_A_DUAL_INA_OADJ]
                           [trim_pkg::OADJ_W-1:0];                  // [RULE3]
         end
      end else if (!op_mode.dual && !op_mode.inb) begin
         out_d.a_oadj_vld = 1'b1;
         out_d.a_oadj     = trim_q[trim_pkg::ENT_A_SGL_INA_OADJ]
                            [trim_pkg::OADJ_W-1:0];                 // [RULE5]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_q <= '0;
      end else begin
         out_q <= out_d;
      end
   end

   assign trim_out = out_q;

   // ==========================================================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_a_tadj;
      !op_mode.dual && op_mode.inb && op_mode.fg_cal |=> trim_out.a_tadj_vld
         && trim_out.a_tadj == $past(trim_q[0][7:0]);
   endproperty
   a_a_tadj: assert property (p_a_tadj)                             // [RULE1]
      else $error("core a timing trim not applied");

   property p_b_tadj;
      !op_mode.dual && op_mode.inb && op_mode.fg_cal |=> trim_out.b_tadj_vld
         && trim_out.b_tadj == $past(trim_q[1][7:0]);
   endproperty
   a_b_tadj: assert property (p_b_tadj)                             // [RULE2]
      else $error("core b timing trim not applied");

   property p_dual_ina;
      op_mode.dual && !op_mode.inb && op_mode.fg_cal |=>
         trim_out.a_oadj_vld && trim_out.a_oadj == $past(trim_q[2][11:0]);
   endproperty
   a_dual_ina: assert property (p_dual_ina)                         // [RULE3]
      else $error("dual first input offset not applied");

   property p_dual_inb;
      op_mode.dual && op_mode.inb && op_mode.fg_cal |=>
         trim_out.a_oadj_vld && trim_out.a_oadj == $past(trim_q[3][11:0]);
   endproperty
   a_dual_inb: assert property (p_dual_inb)                         // [RULE4]
      else $error("dual second input offset not applied");

   property p_sgl_ina;
      !op_mode.dual && !op_mode.inb |=>
         trim_out.a_oadj_vld && trim_out.a_oadj == $past(trim_q[4][11:0]);
   endproperty
   a_sgl_ina: assert property (p_sgl_ina)                           // [RULE5]
      else $error("single first input offset not applied");

   property p_fuse_store;
      ld_we |=> trim_q[$past(ld_ent)] == $past(ld_data);
   endproperty
   a_fuse_store: assert property (p_fuse_store)                     // [RULE6]
      else $error("fuse value not stored in its trim");

   property p_rsvd_zero;
      ld_we |=> trim_q[$past(ld_ent)][15:12] == trim_pkg::RSVD_ZERO;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)                       // [RULE7]
      else $error("reserved offset bits not zero after fuse load");

   property p_sw_write;
      sw_we && !ld_we && dp_idx_q == trim_pkg::IDX_B_SGL_INB_TADJ |=>
         trim_q[1] == {8'h00, $past(hwdata[7:0])};
   endproperty
   a_sw_write: assert property (p_sw_write)                         // [RULE8]
      else $error("software write to timing trim lost");

   property p_read_wait;
      hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait)                       // [RULE8]
      else $error("read data phase not exactly one wait state");

   c_sw_write: cover property (sw_we && dp_idx_q == trim_pkg::IDX_A_SGL_INA_OADJ);
   c_read:     cover property (rd_wait_q && dp_idx_q == trim_pkg::IDX_A_SGL_INB_TADJ);
   c_reload:   cover property (reload_q);

endmodule
`default_nettype wire

/* File: inc/trim_pkg.sv */
// package: register map, field layout and carrier types of the trim bank
package trim_pkg;

   // ==========================================================================
   // register indices (byte address on the bus is index * 4)
   localparam int unsigned IDX_W              = 12;
   localparam logic [11:0] IDX_A_SGL_INB_TADJ = 12'h31a;
   localparam logic [11:0] IDX_B_SGL_INB_TADJ = 12'h31b;
   localparam logic [11:0] IDX_A_DUAL_INA_OADJ = 12'h344;
   localparam logic [11:0] IDX_A_DUAL_INB_OADJ = 12'h346;
   localparam logic [11:0] IDX_A_SGL_INA_OADJ = 12'h348;
   localparam logic [11:0] IDX_STATUS         = 12'h3f0;
   localparam logic [11:0] IDX_CONTROL        = 12'h3f1;

   // ==========================================================================
   // storage layout: one entry per trim register
   localparam int unsigned NUM_TRIMS = 5;
   localparam int unsigned ENT_W     = 3;
   localparam int unsigned TRIM_W    = 16;
   localparam int unsigned TADJ_W    = 8;
   localparam int unsigned OADJ_W    = 12;
   localparam logic [2:0]  ENT_A_SGL_INB_TADJ  = 3'h0;
   localparam logic [2:0]  ENT_B_SGL_INB_TADJ  = 3'h1;
   localparam logic [2:0]  ENT_A_DUAL_INA_OADJ = 3'h2;
   localparam logic [2:0]  ENT_A_DUAL_INB_OADJ = 3'h3;
   localparam logic [2:0]  ENT_A_SGL_INA_OADJ  = 3'h4;
   localparam logic [IDX_W-1:0] TRIM_IDX [NUM_TRIMS] = '{
      IDX_A_SGL_INB_TADJ, IDX_B_SGL_INB_TADJ, IDX_A_DUAL_INA_OADJ,
      IDX_A_DUAL_INB_OADJ, IDX_A_SGL_INA_OADJ};
   // bits that software may write (offset words keep 15:12 writable)
   localparam logic [TRIM_W-1:0] TRIM_MASK [NUM_TRIMS] = '{
      16'h00ff, 16'h00ff, 16'hffff, 16'hffff, 16'hffff};
   // bits that the fuse load fills; reserved offset bits come back zero
   localparam logic [TRIM_W-1:0] FUSE_MASK [NUM_TRIMS] = '{
      16'h00ff, 16'h00ff, 16'h0fff, 16'h0fff, 16'h0fff};
   localparam logic [TRIM_W-1:0] TRIM_RESET = 16'h0000;
   localparam logic [3:0]        RSVD_ZERO  = 4'h0;

   // ==========================================================================
   // status and control bit positions
   localparam int unsigned ST_LOAD_DONE  = 0;
   localparam int unsigned ST_LOAD_BUSY  = 1;
   localparam int unsigned ST_A_TADJ_VLD = 2;
   localparam int unsigned ST_B_TADJ_VLD = 3;
   localparam int unsigned ST_A_OADJ_VLD = 4;
   localparam int unsigned CTL_RELOAD    = 0;

   // ==========================================================================
   // bus constants
   localparam int unsigned ADDR_LSB    = 2;
   localparam logic        HRESP_OKAY  = 1'b0;

   // ==========================================================================
   // carriers
   typedef struct packed {
      logic dual;     // 1: dual channel mode, 0: single channel mode
      logic inb;      // 1: sampling second_analog_input
      logic fg_cal;   // foreground calibration enabled
   } op_mode_t;

   typedef struct packed {
      logic [TADJ_W-1:0] a_tadj;
      logic              a_tadj_vld;
      logic [TADJ_W-1:0] b_tadj;
      logic              b_tadj_vld;
      logic [OADJ_W-1:0] a_oadj;
      logic              a_oadj_vld;
   } trim_out_t;

   typedef enum logic [0:0] {LD_IDLE, LD_REQ} ld_state_t;

endpackage

/* File: rtl/trim_fuse_loader.sv */
// fuse sequencer: copies the factory trims into the register bank
`timescale 1ns/1ps
`default_nettype none
module trim_fuse_loader (
   // clock and reset
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   // control
   input  wire logic                        reload,
   // fuse storage read port
   output logic                             fuse_req,
   output logic [trim_pkg::ENT_W-1:0]       fuse_addr,
   input  wire logic                        fuse_ack,
   input  wire logic [trim_pkg::TRIM_W-1:0] fuse_data,
   // register bank write port
   output logic                             ld_we,
   output logic [trim_pkg::ENT_W-1:0]       ld_ent,
   output logic [trim_pkg::TRIM_W-1:0]      ld_data,
   output logic                             busy,
   output logic                             done
);

   // ==========================================================================
   // state
   trim_pkg::ld_state_t               state_q, state_d;
   logic [trim_pkg::ENT_W-1:0]        ent_q, ent_d;
   logic                              done_q, done_d;

   // walk every entry; reset leaves us in LD_REQ so loading starts at once
   always_comb begin
      state_d = state_q;
      ent_d   = ent_q;
      done_d  = done_q;
      case (state_q)
         trim_pkg::LD_IDLE: begin
            if (reload) begin
               state_d = trim_pkg::LD_REQ;
               ent_d   = '0;
               done_d  = 1'b0;
            end
         end
         trim_pkg::LD_REQ: begin
            if (fuse_ack) begin
               if (ent_q == trim_pkg::ENT_W'(trim_pkg::NUM_TRIMS - 1)) begin
                  state_d = trim_pkg::LD_IDLE;
                  done_d  = 1'b1;
               end else begin
                  ent_d = ent_q + 3'h1;
               end
            end
         end
         default: begin
            state_d = trim_pkg::LD_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= trim_pkg::LD_REQ;
         ent_q   <= '0;
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         ent_q   <= ent_d;
         done_q  <= done_d;
      end
   end

   // request held until the fuse storage answers; data masked to field width
   assign fuse_req  = (state_q == trim_pkg::LD_REQ);
   assign fuse_addr = ent_q;
   assign ld_we     = fuse_req && fuse_ack;                         // [RULE6]
   assign ld_ent    = ent_q;
   assign ld_data   = fuse_data & trim_pkg::FUSE_MASK[ent_q];       // [RULE7]
   assign busy      = fuse_req;
   assign done      = done_q;

   // ==========================================================================
   // checks
   property p_fuse_hold;
      @(posedge hclk) disable iff (!hresetn)
      fuse_req && !fuse_ack |=> fuse_req && $stable(fuse_addr);
   endproperty
   a_fuse_hold: assert property (p_fuse_hold)                       // [RULE6]
      else $error("fuse request dropped or address moved before ack");

   c_load_done: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(done_q));

endmodule
`default_nettype wire

/* File: verif/tb_adc_trim_regs.sv */
// self-checking testbench for the converter core trim register bank
`timescale 1ns/1ps
`default_nettype none
module tb_adc_trim_regs;
   // ==========================================================================
   // clock, reset, bus and side-port signals
   logic                        hclk;
   logic                        hresetn;
   logic                        hsel;
   logic [31:0]                 haddr;
   logic [1:0]                  htrans;
   logic                        hwrite;
   logic [2:0]                  hsize;
   logic [31:0]                 hwdata;
   wire logic                   hready_bus;
   logic                        hreadyout;
   logic [31:0]                 hrdata;
   logic                        hresp;
   trim_pkg::op_mode_t          op_mode;
   logic                        fuse_req;
   logic [trim_pkg::ENT_W-1:0]  fuse_addr;
   logic                        fuse_ack;
   logic [trim_pkg::TRIM_W-1:0] fuse_data;
   trim_pkg::trim_out_t         trim_out;
   int                          bad_count;
   int                          n_compared;
   int                          cyc;
   logic [31:0]                 rd_s;
   logic [15:0]                 fuse_xor;

   // single slave: its ready is the bus ready
   assign hready_bus = hreadyout;

   adc_trim_regs u_dut (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready_bus),
      .hreadyout (hreadyout),
      .hrdata    (hrdata),
      .hresp     (hresp),
      .op_mode   (op_mode),
      .fuse_req  (fuse_req),
      .fuse_addr (fuse_addr),
      .fuse_ack  (fuse_ack),
      .fuse_data (fuse_data),
      .trim_out  (trim_out)
   );

   // ==========================================================================
   // clock and hang guard
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   // the whole run needs under two hundred cycles; this ceiling is generous
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         complete_run;
      end
   end

   // ==========================================================================
   // fuse storage: acks every other cycle, so the loader sees some stall
   function automatic logic [15:0] fuse_word(input logic [2:0] e);
      return (16'hf7c0 + 16'(e) * 16'h0111) ^ fuse_xor;
   endfunction

   always @(posedge hclk) begin
      fuse_ack  <= fuse_req & ~fuse_ack;
      fuse_data <= fuse_word(fuse_addr);
   end

   // ==========================================================================
   // comparison and verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      if (bad_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================================
   // ahb-lite master: hready and hrdata are taken at the falling edge
   // before the rising edge they belong to, so no race with the slave flops
   task automatic wait_ready;
      logic r;
      do begin
         @(negedge hclk);
         r    = hready_bus;
         rd_s = hrdata;
         @(posedge hclk);
      end while (r !== 1'b1);
   endtask

   task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= 1'b1;
      wait_ready;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready;
   endtask

   task automatic ahb_read(input logic [31:0] a, output logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= 1'b0;
      wait_ready;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      wait_ready;
      d = rd_s;
   endtask

   function automatic logic [31:0] trim_addr(input int i);
      return {18'h0, trim_pkg::TRIM_IDX[i], 2'b00};
   endfunction

   // poll status until the fuse load has finished
   task automatic wait_load;
      logic [31:0] st;
      st = 32'h0;
      for (int k = 0; k < 60; k++) begin
         ahb_read({18'h0, trim_pkg::IDX_STATUS, 2'b00}, st);
         if (st[1:0] === 2'b01) break;
      end
      check({30'h0, st[1:0]}, 32'h1);
   endtask

   // every trim must hold the masked fuse word
   task automatic check_fuse;
      logic [31:0] d;
      for (int i = 0; i < 5; i++) begin
         ahb_read(trim_addr(i), d);
         check(d, {16'h0, fuse_word(3'(i)) & trim_pkg::FUSE_MASK[i]});
      end
   endtask

   // ==========================================================================
   // main sequence
   initial begin
      logic [31:0]         d;
      logic [2:0]          mb;
      logic                tv;
      logic                ov;
      logic [11:0]         oval;
      trim_pkg::trim_out_t t;
      bad_count  = 0;
      n_compared = 0;
      cyc        = 0;
      hresetn    = 1'b0;
      hsel       = 1'b0;
      haddr      = 32'h0;
      htrans     = 2'h0;
      hwrite     = 1'b0;
      hsize      = 3'h2;
      hwdata     = 32'h0;
      op_mode    = 3'h0;
      fuse_ack   = 1'b0;
      fuse_data  = 16'h0;
      fuse_xor   = 16'h0;
      repeat (16) @(posedge hclk);
      check({31'h0, hreadyout}, 32'h1);
      check(32'(trim_out), 32'h0);
      hresetn <= 1'b1;
      @(posedge hclk);
      wait_load;
      check_fuse;
      // all ones: timing trims keep eight bits, offsets all sixteen
      for (int i = 0; i < 5; i++) begin
         ahb_write(trim_addr(i), 32'hffffffff);
         ahb_read(trim_addr(i), d);
         check(d, {16'h0, trim_pkg::TRIM_MASK[i]});
      end
      // unmapped index and high address bits must not reach a trim
      ahb_write(32'h00000d14, 32'h00000fff);
      ahb_read(32'h00000d14, d);
      check(d, 32'h0);
      ahb_write(32'h00010c68, 32'h00000077);
      ahb_read(trim_addr(0), d);
      check(d, 32'h000000ff);
      // distinct values, then every operating mode
      ahb_write(trim_addr(0), 32'h000000a1);
      ahb_write(trim_addr(1), 32'h000000b2);
      ahb_write(trim_addr(2), 32'h00000c3d);
      ahb_write(trim_addr(3), 32'h00000d4e);
      ahb_write(trim_addr(4), 32'h00000e5f);
      for (int m = 0; m < 8; m++) begin
         mb = 3'(m);
         op_mode <= mb;
         repeat (2) @(posedge hclk);
         @(negedge hclk);
         t    = trim_out;
         tv   = ~mb[2] & mb[1] & mb[0];
         ov   = (mb[2] & mb[0]) | (~mb[2] & ~mb[1]);
         oval = mb[2] ? (mb[1] ? 12'hd4e : 12'hc3d) : 12'he5f;
         check({29'h0, t.a_tadj_vld, t.b_tadj_vld, t.a_oadj_vld}, {29'h0, tv, tv, ov});
         if (tv) check({16'h0, t.a_tadj, t.b_tadj}, 32'h0000a1b2);
         if (ov) check({20'h0, t.a_oadj}, {20'h0, oval});
         @(posedge hclk);
      end
      // a software change reaches the core while the mode stands
      op_mode <= 3'h3;
      ahb_write(trim_addr(0), 32'h0000005c);
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      check({24'h0, trim_out.a_tadj}, 32'h5c);
      @(posedge hclk);
      // reload from a changed fuse image replaces the software values with the new fuse words
      ahb_write(trim_addr(2), 32'h0000ffff);
      fuse_xor = 16'h5a5a;
      ahb_write({18'h0, trim_pkg::IDX_CONTROL, 2'b00}, 32'h1);
      repeat (3) @(posedge hclk);
      wait_load;
      check_fuse;
      complete_run;
   end
endmodule
`default_nettype wire
